// ### critical_fault_log_trigger_config.sv
// critical fault log trigger selection, configuration registers and log writer
// Function
// - two-bit content field: 00 flags+adc, 01 flags, 10 adc, 11 nothing
// - content bit 2 set starts a log while the external fault line is low
// - index 0x6e bits 0-7 enable undervoltage logging for inputs 1-8
// - index 0x6f bits 0-3 enable undervoltage logging for inputs 9-12
// - index 0x6f bits 4-7 enable overvoltage logging for inputs 1-4
// - index 0x70 bits 0-7 enable overvoltage logging for inputs 5-12
// - index 0x71 bits 0-7 enable early-warning logging for inputs 1-8
// - storing an entry locks the log; writing zero to lock bit re-enables it
// - entries hold reserved, two flag bytes, then thirteen 8-bit adc results
// - a voltage faults only after 2, 4, 8 or 16 consecutive bad conversions
`timescale 1ns/1ps
`include "fault_log_cfg.svh"

module critical_fault_log_trigger_config #(
    parameter int CHANNELS = 12,
    parameter int EW_CHANNELS = 8
) (
    // clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  rst_b,
    // apb slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // comparator and adc inputs
    input  wire logic                  conv_done,
    input  wire logic [CHANNELS-1:0]   uv_raw,
    input  wire logic [CHANNELS-1:0]   ov_raw,
    input  wire logic [EW_CHANNELS-1:0] ew_raw,
    input  wire logic [CHANNELS*8-1:0] adc_value,
    input  wire logic [7:0]            current_adc_value,
    input  wire logic                  external_fault_line_b,
    // status
    output logic                       irq,
    output logic                       log_locked,
    output logic                       log_busy
);

    localparam int FLT_W = 2 * CHANNELS + EW_CHANNELS;

    generate
        if (CHANNELS != 12 || EW_CHANNELS != 8)
        begin : g_check
            $error("register layout serves twelve inputs and eight early-warning inputs");
        end
    endgenerate

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [7:0]                 content;
        logic [7:0]                 uv_low;
        logic [7:0]                 uv_hi_ov_lo;
        logic [7:0]                 ov_high;
        logic [7:0]                 ew_low;
        logic [1:0]                 deglitch;
        logic                       lock;
        logic [7:0]                 irq_status;
        logic [7:0]                 irq_mask;
        fault_log_pkg::log_state_t  st;
        logic [3:0]                 idx;
        logic [1:0]                 sel_snap;
        logic [15:0]                flag_snap;
        logic [31:0]                rdata;
        logic                       ready;
        logic                       err;
        logic                       irq_out;
    } ctrl_state_t;

    ctrl_state_t s_reg;
    ctrl_state_t s_next;

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic [4:0] deglitch_need(input logic [1:0] sel);
        deglitch_need = 5'(`DEGLITCH_BASE << sel);
    endfunction

    function automatic logic is_mapped(input logic [`IDX_W-1:0] idx);
        is_mapped = (idx == `IDX_CONTENT) || (idx == `IDX_UV_LOW) ||
                    (idx == `IDX_UV_HI_OV_LO) || (idx == `IDX_OV_HIGH) ||
                    (idx == `IDX_EW_LOW) || (idx == `IDX_DEGLITCH) ||
                    (idx == `IDX_LOCK) || (idx == `IDX_IRQ_STATUS) ||
                    (idx == `IDX_IRQ_MASK) ||
                    ((idx >= `IDX_LOG_BASE) && (idx <= `IDX_LOG_LAST));
    endfunction

    // ---------------------------------------------------------------
    // deglitch and log storage
    // ---------------------------------------------------------------
    logic [FLT_W-1:0]  flt;
    logic [CHANNELS-1:0] uv_flt;
    logic [CHANNELS-1:0] ov_flt;
    logic [EW_CHANNELS-1:0] ew_flt;
    logic              wr_en;
    logic [7:0]        wr_data;
    logic [3:0]        rd_idx;
    logic [7:0]        rd_data;

    fault_deglitch #(
        .CHANNELS (FLT_W)
    ) u_deglitch (
        .clk_sys  (clk_sys),
        .rst_b    (rst_b),
        .sample   (conv_done),
        .raw      ({ew_raw, ov_raw, uv_raw}),
        .need     (deglitch_need(s_reg.deglitch)),
        .filtered (flt)
    );

    assign uv_flt = flt[CHANNELS-1:0];
    assign ov_flt = flt[2*CHANNELS-1:CHANNELS];
    assign ew_flt = flt[FLT_W-1:2*CHANNELS];

    fault_log_store #(
        .ENTRIES (16)
    ) u_store (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .wr_en   (wr_en),
        .wr_idx  (s_reg.idx),
        .wr_data (wr_data),
        .rd_idx  (rd_idx),
        .rd_data (rd_data)
    );

    // ---------------------------------------------------------------
    // trigger selection
    // ---------------------------------------------------------------
    logic [CHANNELS-1:0]   uv_en;
    logic [CHANNELS-1:0]   ov_en;
    logic [CHANNELS-1:0]   uv_hit;
    logic [CHANNELS-1:0]   ov_hit;
    logic [EW_CHANNELS-1:0] ew_hit;
    logic                  ext_hit;
    logic [CHANNELS-1:0]   mon_hit;
    logic                  trigger;

    assign uv_en   = {s_reg.uv_hi_ov_lo[3:0], s_reg.uv_low};
    assign ov_en   = {s_reg.ov_high, s_reg.uv_hi_ov_lo[7:4]};
    assign uv_hit  = uv_flt & uv_en;
    assign ov_hit  = ov_flt & ov_en;
    assign ew_hit  = ew_flt & s_reg.ew_low;
    assign ext_hit = s_reg.content[`CONTENT_EXT_BIT] & ~external_fault_line_b;
    assign mon_hit = uv_hit | ov_hit | {4'h0, ew_hit};
    assign trigger = (|mon_hit) | ext_hit;

    // ---------------------------------------------------------------
    // log byte source
    // ---------------------------------------------------------------
    logic [3:0] adc_idx;
    logic       flags_on;
    logic       adc_on;

    assign adc_idx  = s_reg.idx - `LOG_ADC_FIRST;
    assign flags_on = ~s_reg.sel_snap[1];
    assign adc_on   = ~s_reg.sel_snap[0];

    always_comb
    begin
        wr_data = `RST_BYTE;
        wr_en   = 1'b0;
        if (s_reg.st == fault_log_pkg::ST_WRITE)
        begin
            if (s_reg.idx <= `LOG_FLAG_LAST)
            begin
                wr_en   = flags_on;
                wr_data = (s_reg.idx == 4'h0) ? `RST_BYTE :
                          (s_reg.idx == 4'h1) ? s_reg.flag_snap[7:0] :
                          s_reg.flag_snap[15:8];
            end
            else
            begin
                wr_en   = adc_on;
                wr_data = (s_reg.idx == `LOG_ENTRY_LAST) ? current_adc_value :
                          adc_value[adc_idx*8 +: 8];
            end
        end
    end

    // ---------------------------------------------------------------
    // apb decode
    // ---------------------------------------------------------------
    logic [`IDX_W-1:0] a_idx;
    logic              a_ok;
    logic              access;
    logic              wr_acc;

    assign a_idx  = paddr[11:2];
    assign a_ok   = (paddr[1:0] == 2'h0) && is_mapped(a_idx);
    assign access = psel & penable & s_reg.ready;
    assign wr_acc = access & pwrite & a_ok;
    assign rd_idx = a_idx[3:0];

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb
    begin
        logic [7:0] wb;
        logic [7:0] ev;
        logic [7:0] rb;
        wb = pwdata[7:0];
        ev = `RST_BYTE;
        rb = `RST_BYTE;
        s_next = s_reg;

        // one wait state: ready rises in the second access cycle
        s_next.ready = psel & penable & ~s_reg.ready;
        s_next.err   = 1'b0;

        if (wr_acc)
        begin
            case (a_idx)
                `IDX_CONTENT:     s_next.content = wb & `CONTENT_USED_MASK;
                `IDX_UV_LOW:      s_next.uv_low = wb;
                `IDX_UV_HI_OV_LO: s_next.uv_hi_ov_lo = wb;
                `IDX_OV_HIGH:     s_next.ov_high = wb;
                `IDX_EW_LOW:      s_next.ew_low = wb;
                `IDX_DEGLITCH:    s_next.deglitch = wb[`DEGLITCH_MSB:`DEGLITCH_LSB];
                `IDX_LOCK:        s_next.lock = wb[`LOCK_BIT];
                `IDX_IRQ_MASK:    s_next.irq_mask = wb & `IRQ_USED_MASK;
                default:          s_next.lock = s_reg.lock;
            endcase
        end

        // log writer
        case (s_reg.st)
            fault_log_pkg::ST_IDLE:
            begin
                // selection 11 turns the logger off entirely, so no lock is taken
                if (trigger && s_reg.content[1:0] != 2'h3)
                begin
                    if (s_reg.lock)
                        ev[`IRQ_BLOCKED_BIT] = 1'b1;
                    else
                    begin
                        s_next.st        = fault_log_pkg::ST_WRITE;
                        s_next.idx       = 4'h0;
                        s_next.sel_snap  = s_reg.content[1:0];
                        s_next.flag_snap = {2'h0, ext_hit, 1'b0, mon_hit};
                    end
                end
            end
            fault_log_pkg::ST_WRITE:
            begin
                s_next.idx = s_reg.idx + 4'h1;
                if (s_reg.idx == `LOG_ENTRY_LAST)
                    s_next.st = fault_log_pkg::ST_LOCK;
            end
            fault_log_pkg::ST_LOCK:
            begin
                s_next.lock = 1'b1;
                ev[`IRQ_DONE_BIT] = 1'b1;
                s_next.st = fault_log_pkg::ST_IDLE;
            end
            default:
                s_next.st = fault_log_pkg::ST_IDLE;
        endcase

        // sticky events: a set in the same cycle as a write-one clear wins
        if (wr_acc && a_idx == `IDX_IRQ_STATUS)
            s_next.irq_status = s_reg.irq_status & ~wb;
        s_next.irq_status = s_next.irq_status | ev;
        s_next.irq_out    = |(s_next.irq_status & s_next.irq_mask);

        // read data prepared during the wait cycle
        case (a_idx)
            `IDX_CONTENT:     rb = s_reg.content;
            `IDX_UV_LOW:      rb = s_reg.uv_low;
            `IDX_UV_HI_OV_LO: rb = s_reg.uv_hi_ov_lo;
            `IDX_OV_HIGH:     rb = s_reg.ov_high;
            `IDX_EW_LOW:      rb = s_reg.ew_low;
            `IDX_DEGLITCH:    rb[`DEGLITCH_MSB:`DEGLITCH_LSB] = s_reg.deglitch;
            `IDX_LOCK:        rb[`LOCK_BIT] = s_reg.lock;
            `IDX_IRQ_STATUS:  rb = s_reg.irq_status;
            `IDX_IRQ_MASK:    rb = s_reg.irq_mask;
            default:          rb = (a_idx >= `IDX_LOG_BASE) ? rd_data : `RST_BYTE;
        endcase
        s_next.rdata = `RST_BYTE;
        if (s_next.ready)
        begin
            s_next.rdata = {24'h0, (pwrite || !a_ok) ? `RST_BYTE : rb};
            // writes into the log area are refused: the entries are read-only
            s_next.err = ~a_ok || (pwrite && a_idx >= `IDX_LOG_BASE) ||
                         (pwrite && a_idx == `IDX_IRQ_STATUS && 1'b0);
        end
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_reg <= '0;
            s_reg.st <= fault_log_pkg::ST_IDLE;
            s_reg.deglitch <= `RST_SEL2;
        end
        else
            s_reg <= s_next;
    end

    assign prdata     = s_reg.rdata;
    assign pready     = s_reg.ready;
    assign pslverr    = s_reg.err;
    assign irq        = s_reg.irq_out;
    assign log_locked = s_reg.lock;
    assign log_busy   = s_reg.st[0]; // gray bit 0 is set in both busy states, so a flop drives the pin

endmodule // critical_fault_log_trigger_config

// ### fault_deglitch.sv
// consecutive-conversion deglitch filter for a group of comparator outputs
`timescale 1ns/1ps
`include "fault_log_cfg.svh"

module fault_deglitch #(
    parameter int CHANNELS = 32
) (
    // clock and reset
    input  wire logic                clk_sys,
    input  wire logic                rst_b,
    // conversion results
    input  wire logic                sample,
    input  wire logic [CHANNELS-1:0] raw,
    input  wire logic [4:0]          need,
    // filtered faults
    output logic      [CHANNELS-1:0] filtered
);

    generate
        if (CHANNELS < 1)
        begin : g_check
            $error("fault_deglitch needs at least one channel");
        end
    endgenerate

    typedef struct packed {
        logic [CHANNELS-1:0][4:0] cnt;
        logic [CHANNELS-1:0]      flt;
    } deglitch_state_t;

    deglitch_state_t state_reg;
    deglitch_state_t state_next;

    // counters saturate at the target so a long fault never wraps back to clear
    always_comb
    begin
        state_next = state_reg;
        for (int i = 0; i < CHANNELS; i++)
        begin
            if (sample)
            begin
                if (!raw[i])
                    state_next.cnt[i] = `CNT_ZERO;
                else if (state_reg.cnt[i] < need)
                    state_next.cnt[i] = state_reg.cnt[i] + `CNT_ONE;
            end
            state_next.flt[i] = (state_next.cnt[i] >= need);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

    assign filtered = state_reg.flt;

endmodule // fault_deglitch

// ### fault_log_cfg.svh
// register indices, field positions, reset values and timing counts of the fault log block
`ifndef FAULT_LOG_CFG_SVH
`define FAULT_LOG_CFG_SVH

// ---------------------------------------------------------------
// register indices (byte address is four times the index)
// ---------------------------------------------------------------
`define IDX_W              10
`define IDX_CONTENT        10'h06d
`define IDX_UV_LOW         10'h06e
`define IDX_UV_HI_OV_LO    10'h06f
`define IDX_OV_HIGH        10'h070
`define IDX_EW_LOW         10'h071
`define IDX_DEGLITCH       10'h074
`define IDX_LOCK           10'h08c
`define IDX_IRQ_STATUS     10'h090
`define IDX_IRQ_MASK       10'h091
`define IDX_LOG_BASE       10'h200
`define IDX_LOG_LAST       10'h20f

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define CONTENT_SEL_MSB    1
`define CONTENT_SEL_LSB    0
`define CONTENT_EXT_BIT    2
`define CONTENT_USED_MASK  8'h07
`define DEGLITCH_MSB       6
`define DEGLITCH_LSB       5
`define LOCK_BIT           1
`define IRQ_DONE_BIT       0
`define IRQ_BLOCKED_BIT    1
`define IRQ_USED_MASK      8'h03
`define LOG_EXT_BIT        5
`define LOG_FLAG_LAST      4'h2
`define LOG_ADC_FIRST      4'h3
`define LOG_ENTRY_LAST     4'hf

// ---------------------------------------------------------------
// reset values and counts
// ---------------------------------------------------------------
`define RST_BYTE           8'h00
`define RST_SEL2           2'h0
`define DEGLITCH_BASE      5'h02
`define CNT_ZERO           5'h00
`define CNT_ONE            5'h01

`endif

// ### fault_log_pkg.sv
// types shared by the fault log block
package fault_log_pkg;

    // ---------------------------------------------------------------
    // log writer states, gray coded along idle -> write -> lock
    // ---------------------------------------------------------------
    typedef enum logic [1:0]
    {
        ST_IDLE  = 2'h0,
        ST_WRITE = 2'h1,
        ST_LOCK  = 2'h3
    } log_state_t;

endpackage

// ### fault_log_props.sv
// concurrent assertions on the ports of the fault log trigger block
`timescale 1ns/1ps
`include "fault_log_cfg.svh"

module fault_log_props (
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        rst_b,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // status
    input wire logic        log_locked,
    input wire logic        log_busy
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    logic lock_clear;
    assign lock_clear = pready && pwrite && (paddr[11:2] == `IDX_LOCK) && !pwdata[`LOCK_BIT];

    // ---------------------------------------------------------------
    // sequences
    // ---------------------------------------------------------------
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_answer;
        !pready ##1 pready;
    endsequence
    // busy through the first eight cycles, then locked and idle seventeen cycles after the rise
    sequence s_logging;
        log_busy [*8] ##10 (!log_busy && log_locked);
    endsequence

    // ---------------------------------------------------------------
    // properties
    // ---------------------------------------------------------------
    a_apb_wait_state: assert property (s_setup |=> s_answer)
        else $error("pready not in second access cycle");
    a_pready_pulse: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    a_prdata_idle_zero: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero outside answer");
    a_prdata_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("prdata upper bits not zero");
    a_err_qualified: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_log_duration: assert property ($rose(log_busy) |-> s_logging)
        else $error("log write did not lock after seventeen cycles");
    a_busy_unlocked: assert property (log_busy |-> !log_locked)
        else $error("log written while locked");
    a_unlock_by_write: assert property ($fell(log_locked) |-> $past(lock_clear))
        else $error("lock dropped without software write");
endmodule // fault_log_props

bind critical_fault_log_trigger_config fault_log_props u_props (
    .clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .log_locked(log_locked), .log_busy(log_busy));

// ### fault_log_store.sv
// sixteen-byte fault log storage held in flip-flops
`timescale 1ns/1ps
`include "fault_log_cfg.svh"

module fault_log_store #(
    parameter int ENTRIES = 16
) (
    // clock and reset
    input  wire logic                       clk_sys,
    input  wire logic                       rst_b,
    // write port
    input  wire logic                       wr_en,
    input  wire logic [$clog2(ENTRIES)-1:0] wr_idx,
    input  wire logic [7:0]                 wr_data,
    // read port
    input  wire logic [$clog2(ENTRIES)-1:0] rd_idx,
    output logic      [7:0]                 rd_data
);

    generate
        if (ENTRIES != 16)
        begin : g_check
            $error("fault_log_store layout needs exactly sixteen entries");
        end
    endgenerate

    typedef struct packed {
        logic [ENTRIES-1:0][7:0] mem;
    } store_state_t;

    store_state_t state_reg;
    store_state_t state_next;

    always_comb
    begin
        state_next = state_reg;
        if (wr_en)
            state_next.mem[wr_idx] = wr_data;
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

    assign rd_data = state_reg.mem[rd_idx];

endmodule // fault_log_store

// ### tb.sv
// self-checking testbench for the fault log trigger block
`timescale 1ns/1ps
`include "fault_log_cfg.svh"

module tb;
    logic        clk_sys = 1'b0;
    logic        rst_b = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        conv_done = 1'b0;
    logic [11:0] uv_raw = 12'h000;
    logic [11:0] ov_raw = 12'h000;
    logic [7:0]  ew_raw = 8'h00;
    logic [95:0] adc_value = 96'h0;
    logic [7:0]  current_adc_value = 8'h00;
    logic        external_fault_line_b = 1'b1;
    logic        irq;
    logic        log_locked;
    logic        log_busy;
    int          n_mismatch = 0;
    int          checks_done = 0;
    logic [31:0] seed = 32'h0001427f;
    logic [31:0] rd;
    logic        err;
    logic [7:0]  log_model [16];
    logic [9:0]  rlist [9] = '{`IDX_CONTENT, `IDX_UV_LOW, `IDX_UV_HI_OV_LO, `IDX_OV_HIGH,
                               `IDX_EW_LOW, `IDX_DEGLITCH, `IDX_LOCK, `IDX_IRQ_STATUS,
                               `IDX_IRQ_MASK};

    always #25 clk_sys = ~clk_sys;

    critical_fault_log_trigger_config DUT (
        .clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .conv_done(conv_done), .uv_raw(uv_raw), .ov_raw(ov_raw), .ew_raw(ew_raw),
        .adc_value(adc_value), .current_adc_value(current_adc_value),
        .external_fault_line_b(external_fault_line_b), .irq(irq), .log_locked(log_locked),
        .log_busy(log_busy));

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function void step();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
    endfunction

    task report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task chk_bit(input logic got, input logic exp, input string what);
        chk_val({31'h0, got}, {31'h0, exp}, what);
    endtask

    // one apb transfer; the slave's answer time is not assumed
    task apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
        int t;
        t = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1 && t < 20)
        begin
            @(posedge clk_sys);
            t++;
        end
        if (t == 20)
            chk_bit(1'b0, 1'b1, "apb answer");
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task pulse(input int n);
        repeat (n)
        begin
            @(posedge clk_sys);
            conv_done <= 1'b1;
            @(posedge clk_sys);
            conv_done <= 1'b0;
        end
    endtask

    initial
    begin
        repeat (40000) @(posedge clk_sys);
        n_mismatch++;
        report_and_stop();
    end

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial
    begin
        int k, j, c, kind, sel, dg, t;
        logic [9:0]  ix;
        logic [7:0]  bt, f1, f2, cur;
        logic [1:0]  msk, st;
        logic [95:0] adcv;
        repeat (8) @(posedge clk_sys);
        rst_b <= 1'b1;
        for (k = 0; k < 16; k++)
            log_model[k] = 8'h00;
        for (k = 0; k < 9; k++)
        begin
            apb(1'b0, rlist[k], 8'h00);
            chk_val(rd, 32'h0, "reset value");
        end
        for (k = 1; k < 5; k++)
        begin
            step();
            apb(1'b1, rlist[k], seed[7:0]);
            apb(1'b0, rlist[k], 8'h00);
            chk_val(rd, {24'h0, seed[7:0]}, "enable readback");
            apb(1'b1, rlist[k], 8'h00);
        end
        apb(1'b1, `IDX_CONTENT, 8'hff);
        apb(1'b0, `IDX_CONTENT, 8'h00);
        chk_val(rd, 32'h07, "content unused bits");
        apb(1'b1, `IDX_CONTENT, 8'h00);
        apb(1'b0, 10'h072, 8'h00);
        chk_bit(err, 1'b1, "unmapped error");
        chk_val(rd, 32'h0, "unmapped data");
        apb(1'b1, 10'h205, 8'h55);
        chk_bit(err, 1'b1, "log write error");
        // every condition present, nothing enabled
        uv_raw <= 12'hfff;
        ov_raw <= 12'hfff;
        ew_raw <= 8'hff;
        external_fault_line_b <= 1'b0;
        pulse(17);
        chk_bit(log_locked, 1'b0, "disabled conditions");
        uv_raw <= 12'h000;
        ov_raw <= 12'h000;
        ew_raw <= 8'h00;
        external_fault_line_b <= 1'b1;
        pulse(1);
        for (k = 0; k < 9; k++)
        begin
            step();
            kind = k % 4;
            sel = (k == 8) ? 3 : k % 3;
            dg = (k / 2) % 4;
            c = int'(seed[7:0]) % ((kind == 2) ? 8 : 12);
            f1 = (c < 8) ? 8'h01 << c : 8'h00;
            f2 = (c < 8) ? 8'h00 : 8'h01 << (c - 8);
            ix = (c < 8) ? `IDX_UV_LOW : `IDX_UV_HI_OV_LO;
            bt = 8'h01 << (c % 8);
            if (kind == 1)
            begin
                ix = (c < 4) ? `IDX_UV_HI_OV_LO : `IDX_OV_HIGH;
                bt = (c < 4) ? 8'h01 << (c + 4) : 8'h01 << (c - 4);
            end
            if (kind == 2)
                ix = `IDX_EW_LOW;
            if (kind == 3)
            begin
                f1 = 8'h00;
                f2 = 8'h20;
            end
            else
                apb(1'b1, ix, bt);
            apb(1'b1, `IDX_DEGLITCH, 8'(dg << 5));
            apb(1'b1, `IDX_CONTENT, {5'h0, kind == 3, 2'(sel)});
            msk = seed[9:8];
            apb(1'b1, `IDX_IRQ_MASK, {6'h0, msk});
            step();
            adcv = {seed, seed ^ 32'h5a5a5a5a, ~seed};
            cur = seed[15:8];
            adc_value <= adcv;
            current_adc_value <= cur;
            case (kind)
                0: uv_raw[c] <= 1'b1;
                1: ov_raw[c] <= 1'b1;
                2: ew_raw[c] <= 1'b1;
                default: external_fault_line_b <= 1'b0;
            endcase
            pulse((kind < 2) ? (2 << dg) - 1 : 2 << dg);
            if (kind < 2)
            begin
                repeat (2) @(posedge clk_sys);
                chk_bit(log_busy | log_locked, 1'b0, "count not reached");
                pulse(1);
            end
            t = 0;
            while (log_locked !== 1'b1 && t < 40)
            begin
                @(posedge clk_sys);
                t++;
            end
            chk_bit(log_locked, sel != 3, "log stored");
            if (sel != 3 && sel != 2)
            begin
                log_model[0] = 8'h00;
                log_model[1] = f1;
                log_model[2] = f2;
            end
            if (sel != 3 && sel != 1)
            begin
                for (j = 0; j < 12; j++)
                    log_model[3 + j] = adcv[8 * j +: 8];
                log_model[15] = cur;
            end
            for (j = 0; j < 16; j++)
            begin
                apb(1'b0, 10'(`IDX_LOG_BASE + j), 8'h00);
                chk_val(rd, {24'h0, log_model[j]}, "log byte");
            end
            st = (sel == 3) ? 2'h0 : 2'h3;
            apb(1'b0, `IDX_IRQ_STATUS, 8'h00);
            chk_val(rd, {30'h0, st}, "status while locked");
            chk_bit(irq, |(st & msk), "irq level");
            uv_raw <= 12'h000;
            ov_raw <= 12'h000;
            ew_raw <= 8'h00;
            external_fault_line_b <= 1'b1;
            pulse(1);
            apb(1'b1, `IDX_IRQ_STATUS, 8'h03);
            apb(1'b0, `IDX_IRQ_STATUS, 8'h00);
            chk_val(rd, 32'h0, "status cleared");
            chk_bit(irq, 1'b0, "irq cleared");
            if (kind != 3)
                apb(1'b1, ix, 8'h00);
            apb(1'b1, `IDX_LOCK, 8'h00);
            repeat (3) @(posedge clk_sys);
            chk_bit(log_locked, 1'b0, "unlocked");
        end
        report_and_stop();
    end
endmodule // tb
